/* brk_pkg.sv */
/*
  Shared constants of the user break unit: register byte offsets,
  field positions, reset values and match encodings.
  Assumes a 32-bit Avalon-MM register slave with word addressing
  expressed in bytes.
*/
package brk_pkg;
  // Register byte offsets
  localparam logic [5:0] off_a_addr = 6'h00;
  localparam logic [5:0] off_a_asid = 6'h04;
  localparam logic [5:0] off_a_amask = 6'h08;
  localparam logic [5:0] off_a_bus = 6'h0c;
  localparam logic [5:0] off_b_addr = 6'h10;
  localparam logic [5:0] off_b_asid = 6'h14;
  localparam logic [5:0] off_b_amask = 6'h18;
  localparam logic [5:0] off_b_data = 6'h1c;
  localparam logic [5:0] off_b_dmask = 6'h20;
  localparam logic [5:0] off_b_bus = 6'h24;
  localparam logic [5:0] off_ctrl = 6'h28;
  // Writable bits of the narrow registers, then the bus cycle reset value
  localparam logic [7:0] amask_bits = 8'h0f;
  localparam logic [15:0] bus_bits = 16'h007f;
  localparam logic [15:0] ctrl_bits = 16'hc4c9;
  localparam logic [15:0] bus_reset = 16'h0000;
  // Control register fields
  localparam int ctl_flag_a = 15;
  localparam int ctl_flag_b = 14;
  localparam int ctl_pcb_a = 10;
  localparam int ctl_dbe_b = 7;
  localparam int ctl_pcb_b = 6;
  localparam int ctl_chain = 3;
  localparam int ctl_debug = 0;
  // Address mask register fields
  localparam int am_asid = 2;
  // Bus cycle register fields
  localparam int bc_sz2 = 6;
  localparam int bc_id_lo = 4;
  localparam int bc_rw_lo = 2;
  // Access type field codes
  localparam logic [1:0] id_none = 2'h0;
  localparam logic [1:0] id_instr = 2'h1;
  localparam logic [1:0] id_operand = 2'h2;
  localparam logic [1:0] id_either = 2'h3;
  // Address mask codes
  localparam logic [2:0] am_none = 3'h0;
  localparam logic [2:0] am_low10 = 3'h1;
  localparam logic [2:0] am_low12 = 3'h2;
  localparam logic [2:0] am_all = 3'h3;
  localparam logic [2:0] am_low16 = 3'h4;
  localparam logic [2:0] am_low20 = 3'h5;
  // Bus handshake states
  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_ack = 2'b10
  } bus_state_type;
endpackage

/* break_unit.sv */
/*
  User break unit with channels A and B, data compare on channel B and
  the shared break control register.
  Assumes CPU access inputs synchronous to ref_clk, one access per
  cycle at most, and an Avalon-MM master honouring waitrequest.

*/
`timescale 1ns/1ps
module break_unit #(
  parameter int data_width = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic acc_instr,
  input wire logic acc_write,
  input wire logic [2:0] acc_size,
  input wire logic [31:0] acc_address,
  input wire logic [7:0] acc_space_id,
  input wire logic [data_width-1:0] acc_data,
  output logic break_request,
  output logic break_post_exec,
  output logic debug_support_enable
);

  // Bit mask of compared address bits for a mask code
  function automatic logic [31:0] addr_care(input logic [2:0] code);
    case (code)
      brk_pkg::am_none: addr_care = 32'hffffffff;
      brk_pkg::am_low10: addr_care = 32'hfffffc00;
      brk_pkg::am_low12: addr_care = 32'hfffff000;
      brk_pkg::am_all: addr_care = 32'h00000000;
      brk_pkg::am_low16: addr_care = 32'hffff0000;
      brk_pkg::am_low20: addr_care = 32'hfff00000;
      default: addr_care = 32'h00000000;
    endcase
  endfunction

  // Address, space id, access type, direction and size agreement
  function automatic logic chan_hit(
    input logic [31:0] addr,
    input logic [7:0] asid,
    input logic [7:0] amask,
    input logic [15:0] bus,
    input logic valid,
    input logic instr,
    input logic wr,
    input logic [2:0] size,
    input logic [31:0] a_in,
    input logic [7:0] s_in
  );
    logic [2:0] code;
    logic [1:0] id;
    logic [1:0] rw;
    logic [2:0] sz;
    code = {amask[3], amask[1:0]};
    id = bus[brk_pkg::bc_id_lo +: 2];
    rw = bus[brk_pkg::bc_rw_lo +: 2];
    sz = {bus[brk_pkg::bc_sz2], bus[1:0]};
    chan_hit = valid
      && (((a_in ^ addr) & addr_care(code)) == 32'h0)
      && (amask[brk_pkg::am_asid] || (s_in == asid))
      && ((id[0] && instr) || (id[1] && !instr))
      && ((rw[0] && !wr) || (rw[1] && wr))
      && ((sz == 3'h0) || (sz == size));
  endfunction

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Channel registers; channel B adds data and data mask registers
  logic [31:0] a_addr;
  logic [7:0] a_asid;
  logic [7:0] a_amask;
  logic [15:0] a_bus;
  logic [31:0] b_addr;
  logic [7:0] b_asid;
  logic [7:0] b_amask;
  logic [15:0] b_bus;
  logic [data_width-1:0] b_data;
  logic [data_width-1:0] b_dmask;
  // Control register pieces
  logic flag_a;
  logic flag_b;
  logic debug_en;
  logic pcb_a;
  logic pcb_b;
  logic dbe_b;
  logic chain;
  logic a_held;
  brk_pkg::bus_state_type bus_state;
  brk_pkg::bus_state_type next_bus_state;

  // Bus handshake: one wait cycle, commit at the acknowledge edge
  wire logic bus_req = avs_read || avs_write;
  wire logic commit = (bus_state == brk_pkg::bus_ack);
  wire logic wr_go = commit && avs_write;
  assign avs_waitrequest = bus_req && !commit;

  // Register select strobes
  wire logic sel_a_addr = wr_go && (avs_address == brk_pkg::off_a_addr);
  wire logic sel_a_asid = wr_go && (avs_address == brk_pkg::off_a_asid);
  wire logic sel_a_amask = wr_go && (avs_address == brk_pkg::off_a_amask);
  wire logic sel_a_bus = wr_go && (avs_address == brk_pkg::off_a_bus);
  wire logic sel_b_addr = wr_go && (avs_address == brk_pkg::off_b_addr);
  wire logic sel_b_asid = wr_go && (avs_address == brk_pkg::off_b_asid);
  wire logic sel_b_amask = wr_go && (avs_address == brk_pkg::off_b_amask);
  wire logic sel_b_data = wr_go && (avs_address == brk_pkg::off_b_data);
  wire logic sel_b_dmask = wr_go && (avs_address == brk_pkg::off_b_dmask);
  wire logic sel_b_bus = wr_go && (avs_address == brk_pkg::off_b_bus);
  wire logic sel_ctrl = wr_go && (avs_address == brk_pkg::off_ctrl);
  wire logic ctrl_lo = sel_ctrl && avs_byteenable[0];
  wire logic ctrl_hi = sel_ctrl && avs_byteenable[1];

  // Control register as software sees it
  wire logic [15:0] ctrl_view = {flag_a, flag_b, 3'h0, pcb_a, 2'h0,
    dbe_b, pcb_b, 2'h0, chain, 2'h0, debug_en};

  // Narrow writes with reserved bits forced to zero
  wire logic [31:0] wd_amask_a = merge({24'h0, a_amask}, avs_writedata,
    avs_byteenable);
  wire logic [31:0] wd_amask_b = merge({24'h0, b_amask}, avs_writedata,
    avs_byteenable);
  wire logic [31:0] wd_bus_a = merge({16'h0, a_bus}, avs_writedata,
    avs_byteenable);
  wire logic [31:0] wd_bus_b = merge({16'h0, b_bus}, avs_writedata,
    avs_byteenable);

  // Read multiplexer; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      brk_pkg::off_a_addr: rd_mux = a_addr;
      brk_pkg::off_a_asid: rd_mux = {24'h0, a_asid};
      brk_pkg::off_a_amask: rd_mux = {24'h0, a_amask};
      brk_pkg::off_a_bus: rd_mux = {16'h0, a_bus};
      brk_pkg::off_b_addr: rd_mux = b_addr;
      brk_pkg::off_b_asid: rd_mux = {24'h0, b_asid};
      brk_pkg::off_b_amask: rd_mux = {24'h0, b_amask};
      brk_pkg::off_b_data: rd_mux = 32'(b_data);
      brk_pkg::off_b_dmask: rd_mux = 32'(b_dmask);
      brk_pkg::off_b_bus: rd_mux = {16'h0, b_bus};
      brk_pkg::off_ctrl: rd_mux = {16'h0, ctrl_view};
      default: rd_mux = 32'h0;
    endcase
  end

  // Handshake state
  always_comb begin
    case (bus_state)
      brk_pkg::bus_idle: next_bus_state = bus_req ? brk_pkg::bus_ack
        : brk_pkg::bus_idle;
      brk_pkg::bus_ack: next_bus_state = brk_pkg::bus_idle;
      default: next_bus_state = brk_pkg::bus_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_state <= brk_pkg::bus_idle;
      avs_readdata <= 32'h0;
    end else begin
      bus_state <= next_bus_state;
      if (bus_req && !commit) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Compare values other than the bus cycle regs survive every reset, so no reset branch here
  always_ff @(posedge ref_clk) begin
    if (sel_a_addr) begin
      a_addr <= merge(a_addr, avs_writedata, avs_byteenable);
    end
    if (sel_a_asid && avs_byteenable[0]) begin
      a_asid <= avs_writedata[7:0];
    end
    if (sel_a_amask) begin
      a_amask <= wd_amask_a[7:0] & brk_pkg::amask_bits;
    end
    if (sel_b_addr) begin
      b_addr <= merge(b_addr, avs_writedata, avs_byteenable);
    end
    if (sel_b_asid && avs_byteenable[0]) begin
      b_asid <= avs_writedata[7:0];
    end
    if (sel_b_amask) begin
      b_amask <= wd_amask_b[7:0] & brk_pkg::amask_bits;
    end
    if (sel_b_data) begin
      b_data <= data_width'(merge(32'(b_data), avs_writedata,
        avs_byteenable));
    end
    if (sel_b_dmask) begin
      b_dmask <= data_width'(merge(32'(b_dmask), avs_writedata,
        avs_byteenable));
    end
    if (ctrl_hi) begin
      pcb_a <= avs_writedata[brk_pkg::ctl_pcb_a];
    end
    if (ctrl_lo) begin
      dbe_b <= avs_writedata[brk_pkg::ctl_dbe_b];
      pcb_b <= avs_writedata[brk_pkg::ctl_pcb_b];
      chain <= avs_writedata[brk_pkg::ctl_chain];
    end
  end

  // Channel evaluation; bus cycle fields gate every match
  wire logic hit_a = chan_hit(a_addr, a_asid, a_amask, a_bus, acc_valid,
    acc_instr, acc_write, acc_size, acc_address, acc_space_id);
  wire logic hit_b_core = chan_hit(b_addr, b_asid, b_amask, b_bus,
    acc_valid, acc_instr, acc_write, acc_size, acc_address,
    acc_space_id);
  // Data compare only on operand accesses; mask bit 1 excludes a bit
  wire logic data_ok = !dbe_b || acc_instr
    || (((acc_data ^ b_data) & ~b_dmask) == '0);
  wire logic hit_b = hit_b_core && data_ok;
  // Chained mode: B counts only after an earlier A match held in a_held
  wire logic eff_a = hit_a && !chain;
  wire logic eff_b = hit_b && (!chain || a_held);
  wire logic chain_clear = ctrl_lo && !avs_writedata[brk_pkg::ctl_chain];
  wire logic post_sel = eff_b ? pcb_b : pcb_a;

  // Flags: hardware sets, software write of 0 clears, set wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      debug_en <= 1'b0;
      a_bus <= brk_pkg::bus_reset;
      b_bus <= brk_pkg::bus_reset;
      a_held <= 1'b0;
      break_request <= 1'b0;
      break_post_exec <= 1'b0;
    end else begin
      flag_a <= eff_a || (flag_a && !(ctrl_hi
        && !avs_writedata[brk_pkg::ctl_flag_a]));
      flag_b <= eff_b || (flag_b && !(ctrl_hi
        && !avs_writedata[brk_pkg::ctl_flag_b]));
      if (ctrl_lo) begin
        debug_en <= avs_writedata[brk_pkg::ctl_debug];
      end
      if (sel_a_bus) begin
        a_bus <= wd_bus_a[15:0] & brk_pkg::bus_bits;
      end
      if (sel_b_bus) begin
        b_bus <= wd_bus_b[15:0] & brk_pkg::bus_bits;
      end
      if (chain_clear || eff_b) begin
        a_held <= 1'b0;
      end else if (chain && hit_a) begin
        a_held <= 1'b1;
      end
      break_request <= eff_a || eff_b;
      break_post_exec <= (eff_a || eff_b) && acc_instr && post_sel;
    end
  end

  assign debug_support_enable = debug_en;

  // Checks
  chk_flag_a_set: assert property (@(posedge ref_clk) disable iff (reset)
    eff_a |=> flag_a) else $error("flag a not set");
  chk_flag_b_set: assert property (@(posedge ref_clk) disable iff (reset)
    eff_b |=> flag_b) else $error("flag b not set");
  chk_flag_a_hold: assert property (@(posedge ref_clk) disable iff (reset)
    flag_a && !ctrl_hi |=> flag_a) else $error("flag a lost");
  chk_flag_b_hold: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(flag_b) |-> $past(ctrl_hi)) else $error("flag b lost");
  // Watch the read path itself, so a stray mux bit is caught too
  chk_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    commit && avs_read && (avs_address == brk_pkg::off_ctrl)
    |-> (avs_readdata & ~{16'h0000, brk_pkg::ctrl_bits}) == 32'h0)
    else $error("reserved bit set");
  chk_chain_gate: assert property (@(posedge ref_clk) disable iff (reset)
    chain && !a_held && hit_b |=> !flag_b || $past(flag_b))
    else $error("chained b early");
  chk_chain_no_a: assert property (@(posedge ref_clk) disable iff (reset)
    chain && !flag_a |=> !flag_a) else $error("chained a flagged");
  chk_chain_drop: assert property (@(posedge ref_clk) disable iff (reset)
    chain_clear |=> !a_held) else $error("held a kept");
  chk_data_mask: assert property (@(posedge ref_clk) disable iff (reset)
    hit_b_core && dbe_b && !acc_instr && !chain && !hit_a
    && (((acc_data ^ b_data) & ~b_dmask) != '0) |=> !break_request)
    else $error("masked data hit");
  chk_post_sel: assert property (@(posedge ref_clk) disable iff (reset)
    break_post_exec |-> $past(acc_instr) && break_request)
    else $error("post without instr");
  chk_debug_out: assert property (@(posedge ref_clk) disable iff (reset)
    ctrl_lo |=> debug_support_enable == $past(avs_writedata[0]))
    else $error("debug enable wrong");
  chk_bus_answer: assert property (@(posedge ref_clk) disable iff (reset)
    bus_req && !commit |=> !avs_waitrequest)
    else $error("no bus answer");

  cov_break_a: cover property (@(posedge ref_clk) disable iff (reset)
    eff_a);
  cov_break_b_data: cover property (@(posedge ref_clk) disable iff (reset)
    eff_b && dbe_b);
  cov_chained: cover property (@(posedge ref_clk) disable iff (reset)
    chain && a_held && eff_b);
  cov_set_clear: cover property (@(posedge ref_clk) disable iff (reset)
    eff_b && ctrl_hi);
endmodule

/* cpu_access_model.sv */
/*
  CPU core access port model: one operand or instruction access at a time.
  Assumes calls are made just after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
module cpu_access_model (
  input wire logic ref_clk,
  output logic acc_valid,
  output logic acc_instr,
  output logic acc_write,
  output logic [2:0] acc_size,
  output logic [31:0] acc_address,
  output logic [7:0] acc_space_id,
  output logic [31:0] acc_data
);
  // Operand size driven on later accesses; longword unless changed
  logic [2:0] size_code = 3'h3;

  // Idle bus from time zero
  initial begin
    acc_valid = 1'b0;
    acc_instr = 1'b0;
    acc_write = 1'b0;
    acc_size = 3'h0;
    acc_address = 32'h0;
    acc_space_id = 8'h0;
    acc_data = 32'h0;
  end

  // One access cycle; stale lines inverted so nothing matches by leftover
  task automatic drive(input logic i, input logic w, input logic [31:0] ad,
                       input logic [31:0] dt);
    acc_valid <= 1'b1;
    acc_instr <= i;
    acc_write <= w;
    acc_size <= size_code;
    acc_address <= ad;
    acc_space_id <= 8'h05;
    acc_data <= dt;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    acc_instr <= !i;
    acc_write <= !w;
    acc_size <= 3'h4;
    acc_address <= ~ad;
    acc_space_id <= 8'hfa;
    acc_data <= ~dt;
  endtask

  // Select the operand size of the following accesses
  task automatic set_size(input logic [2:0] s);
    size_code = s;
  endtask
endmodule

/* tb_top.sv */
/*
  Self-checking bench for the break unit: register bus, channel matching.
  Assumes the access model as far side and a bus answer within 20 wait cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, acc_address, acc_data;
  logic avs_waitrequest, acc_valid, acc_instr, acc_write;
  logic break_request, break_post_exec, debug_support_enable;
  logic [2:0] acc_size;
  logic [7:0] acc_space_id;
  logic [7:0] mk [10] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h08, 8'h08, 8'h09, 8'h09, 8'h03, 8'h00};
  int bt [10] = '{9, 10, 11, 12, 15, 16, 19, 20, 31, 2};
  logic ex [10] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
  int n_mismatch = 0;
  int samples_checked = 0;
  localparam logic [31:0] aa = 32'h0000_1000;
  localparam logic [31:0] ba = 32'h0000_2000;

  break_unit u_break_unit (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc_instr(acc_instr),
    .acc_write(acc_write), .acc_size(acc_size), .acc_address(acc_address),
    .acc_space_id(acc_space_id), .acc_data(acc_data), .break_request(break_request),
    .break_post_exec(break_post_exec), .debug_support_enable(debug_support_enable));
  cpu_access_model u_cpu_access_model (.ref_clk(ref_clk), .acc_valid(acc_valid),
    .acc_instr(acc_instr), .acc_write(acc_write), .acc_size(acc_size),
    .acc_address(acc_address), .acc_space_id(acc_space_id), .acc_data(acc_data));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = !ref_clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bus cycle; one idle edge after release so requests never collide
  task automatic bus_op(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) `CHK(n, 0)
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus_op(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask

  // One access, then judge the break pulse in the following cycle
  task automatic acc(input logic i, input logic w, input logic [31:0] ad,
                     input logic [31:0] dt, input logic eb, input logic ep);
    u_cpu_access_model.drive(i, w, ad, dt);
    #1;
    `CHK(break_request, eb)
    if (eb) `CHK(break_post_exec, ep)
    @(posedge ref_clk);
  endtask

  // Address, space id, mask, control first; bus cycle regs last
  task automatic setup(input logic [15:0] c, input logic [15:0] ab, input logic [15:0] bb);
    bus_op(1'b1, brk_pkg::off_a_addr, aa);
    bus_op(1'b1, brk_pkg::off_b_addr, ba);
    bus_op(1'b1, brk_pkg::off_a_asid, 32'h05);
    bus_op(1'b1, brk_pkg::off_b_asid, 32'h05);
    bus_op(1'b1, brk_pkg::off_a_amask, 32'h0);
    bus_op(1'b1, brk_pkg::off_b_amask, 32'h0);
    bus_op(1'b1, brk_pkg::off_ctrl, {16'h0, c});
    bus_op(1'b1, brk_pkg::off_a_bus, {16'h0, ab});
    bus_op(1'b1, brk_pkg::off_b_bus, {16'h0, bb});
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Reset values, reserved bits, unmapped place, data regs across reset
  task automatic t_regs();
    rchk(brk_pkg::off_ctrl, 32'hffff_c001, 32'h0);
    rchk(brk_pkg::off_b_bus, 32'hffff_ffff, 32'h0);
    `CHK(debug_support_enable, 1'b0)
    bus_op(1'b1, brk_pkg::off_b_data, 32'ha5a5_3c3c);
    bus_op(1'b1, brk_pkg::off_b_dmask, 32'h5a5a_c3c3);
    bus_op(1'b1, brk_pkg::off_b_amask, 32'h0000_000f);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0000_c4c9);
    rchk(brk_pkg::off_ctrl, 32'hffff_ffff, 32'h0000_04c9);
    rchk(brk_pkg::off_b_amask, 32'hffff_ffff, 32'h0000_000f);
    rchk(6'h2c, 32'hffff_ffff, 32'h0);
    `CHK(debug_support_enable, 1'b1)
    do_reset();
    rchk(brk_pkg::off_b_data, 32'hffff_ffff, 32'ha5a5_3c3c);
    rchk(brk_pkg::off_b_dmask, 32'hffff_ffff, 32'h5a5a_c3c3);
    rchk(brk_pkg::off_ctrl, 32'hffff_c001, 32'h0);
  endtask

  // Plain matches, sticky flags, software clear
  task automatic t_match();
    setup(16'h0001, 16'h0000, 16'h0027);
    acc(1'b0, 1'b0, ba, 32'h0, 1'b1, 1'b0);
    acc(1'b0, 1'b1, ba, 32'h0, 1'b0, 1'b0);
    acc(1'b0, 1'b0, ba + 32'h4, 32'h0, 1'b0, 1'b0);
    rchk(brk_pkg::off_ctrl, 32'h0000_c000, 32'h0000_4000);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0001);
    rchk(brk_pkg::off_ctrl, 32'h0000_c000, 32'h0);
    setup(16'h0001, 16'h0027, 16'h0000);
    acc(1'b0, 1'b0, aa, 32'h0, 1'b1, 1'b0);
    rchk(brk_pkg::off_ctrl, 32'h0000_c000, 32'h0000_8000);
  endtask

  // Data compare with per-bit mask, then disabled
  task automatic t_data();
    bus_op(1'b1, brk_pkg::off_b_data, 32'h1234_5678);
    bus_op(1'b1, brk_pkg::off_b_dmask, 32'h0000_00ff);
    setup(16'h0081, 16'h0000, 16'h0027);
    acc(1'b0, 1'b0, ba, 32'h1234_56aa, 1'b1, 1'b0);
    acc(1'b0, 1'b0, ba, 32'h1334_5678, 1'b0, 1'b0);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0001);
    acc(1'b0, 1'b0, ba, 32'h1334_5678, 1'b1, 1'b0);
    bus_op(1'b1, brk_pkg::off_b_data, 32'h0000_3c3c);
    bus_op(1'b1, brk_pkg::off_b_dmask, 32'hffff_0000);
    setup(16'h0081, 16'h0000, 16'h0025);
    acc(1'b0, 1'b0, ba, 32'h0000_3c3c, 1'b0, 1'b0);
    u_cpu_access_model.set_size(3'h1);
    acc(1'b0, 1'b0, ba, 32'hbeef_3c3c, 1'b1, 1'b0);
    acc(1'b0, 1'b0, ba, 32'h0000_3c3d, 1'b0, 1'b0);
    u_cpu_access_model.set_size(3'h3);
  endtask

  // Every access type code, pre and post select, every mask code
  task automatic t_modes();
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      setup(16'h0001, 16'h0000, 16'h0007 | {10'h0, c, 4'h0});
      acc(1'b1, 1'b0, ba, 32'h0, c[0], 1'b0);
      acc(1'b0, 1'b0, ba, 32'h0, c[1], 1'b0);
    end
    setup(16'h0441, 16'h0017, 16'h0017);
    acc(1'b1, 1'b0, aa, 32'h0, 1'b1, 1'b1);
    acc(1'b1, 1'b0, ba, 32'h0, 1'b1, 1'b1);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0401);
    acc(1'b1, 1'b0, aa, 32'h0, 1'b1, 1'b1);
    acc(1'b1, 1'b0, ba, 32'h0, 1'b1, 1'b0);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0041);
    acc(1'b1, 1'b0, aa, 32'h0, 1'b1, 1'b0);
    acc(1'b1, 1'b0, ba, 32'h0, 1'b1, 1'b1);
    setup(16'h0001, 16'h0000, 16'h0027);
    for (int k = 0; k < 10; k++) begin
      bus_op(1'b1, brk_pkg::off_b_amask, {24'h0, mk[k]});
      acc(1'b0, 1'b0, ba ^ (32'h1 << bt[k]), 32'h0, ex[k], 1'b0);
    end
  endtask

  // Chained mode: held A match, B break, discard on select clear
  task automatic t_chain();
    setup(16'h0009, 16'h0027, 16'h0027);
    acc(1'b0, 1'b0, aa, 32'h0, 1'b0, 1'b0);
    acc(1'b0, 1'b0, ba, 32'h0, 1'b1, 1'b0);
    rchk(brk_pkg::off_ctrl, 32'h0000_c000, 32'h0000_4000);
    acc(1'b0, 1'b0, ba, 32'h0, 1'b0, 1'b0);
    acc(1'b0, 1'b0, aa, 32'h0, 1'b0, 1'b0);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0001);
    bus_op(1'b1, brk_pkg::off_ctrl, 32'h0009);
    acc(1'b0, 1'b0, ba, 32'h0, 1'b0, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_match();
    t_data();
    t_modes();
    t_chain();
    report_and_stop();
  end

  // Hang guard, far beyond the roughly 500 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
